// *** rtl/lphc_pkg.sv ***
// package for the lane pattern / high-pass filter / input select register pair and the individual select mode register
// assumes a 32-bit apb slave with word-aligned registers
// Functional notes
// - per-lane pattern fields act only while individual pattern select is one
// - four prbs enables, one per lane, bits 15 down to 12 of first register
// - pattern codes for lane 1 at bits 11-9, lane 2 at 8-6, first register
// - pattern codes for lane 3 at bits 7-5, lane 4 at 4-2, second register
// - rounding bit zero truncates filter output, one rounds it
// - corner k in bits 4-1, valid from 2 to 10
// - corner k applies to converters 1-4 only while filter enabled
// - bit 0 enables filter for converters 1-4, default zero means bypass
// - converter 1 picks pair 1 or 2 by bit 11, converter 2 pair 3 or 4 by bit 10
// - converter 3 picks pair 5 or 6 by bit 9, converter 4 pair 7 or 8 by bit 8
package lphc_pkg;
	localparam int LPHC_REG_W = 16;
	// printed offsets 15h and 17h are not multiples of four: kept as indices
	localparam logic [7:0] LPHC_IDX_CTRL = 8'h15;
	localparam logic [7:0] LPHC_IDX_INSEL = 8'h17;
	localparam logic [7:0] LPHC_IDX_MODE = 8'h20;
	localparam logic [9:0] LPHC_ADDR_CTRL = {LPHC_IDX_CTRL, 2'b00};
	localparam logic [9:0] LPHC_ADDR_INSEL = {LPHC_IDX_INSEL, 2'b00};
	localparam logic [9:0] LPHC_ADDR_MODE = {LPHC_IDX_MODE, 2'b00};
	localparam logic [15:0] LPHC_RST_VAL = 16'h0000;
	localparam logic [15:0] LPHC_CTRL_MASK = 16'hffff;
	localparam logic [15:0] LPHC_INSEL_MASK = 16'h0ffc;
	localparam logic [15:0] LPHC_MODE_MASK = 16'h0001;
	localparam int LPHC_PRBS_LSB = 12;
	localparam int LPHC_PAT1_LSB = 9;
	localparam int LPHC_PAT2_LSB = 6;
	localparam int LPHC_ROUND_BIT = 5;
	localparam int LPHC_K_LSB = 1;
	localparam int LPHC_HPF_EN_BIT = 0;
	localparam int LPHC_PAT3_LSB = 5;
	localparam int LPHC_PAT4_LSB = 2;
	localparam int LPHC_INSEL_LSB = 8;
	localparam int LPHC_INDSEL_BIT = 0;
	localparam logic [3:0] LPHC_K_MIN = 4'h2;
	localparam logic [3:0] LPHC_K_MAX = 4'ha;

	typedef struct packed {
		logic [3:0] prbs_en;
		logic [3:0][2:0] code;
	} lphc_lane_cfg_t;

	typedef struct packed {
		logic enable;
		logic round;
		logic [3:0] k;
		logic k_valid;
	} lphc_hpf_cfg_t;
endpackage : lphc_pkg

// *** rtl/lphc_lane_gate.sv ***
// gates per-lane pattern fields by the individual select bit
// assumes all inputs come from registers on the same clock
`timescale 1ns/1ps
module lphc_lane_gate
	import lphc_pkg::*;
(
	input wire logic ind_sel, // individual pattern select
	input wire logic [3:0] prbs_in, // raw prbs enables
	input wire logic [11:0] code_in, // raw codes, lane 1 low
	output lphc_lane_cfg_t lane_out // effective lane config
);
	// fields are ignored, not cleared, when select drops
	assign lane_out.prbs_en = ind_sel ? prbs_in : 4'h0;
	assign lane_out.code = ind_sel ? code_in : 12'h000;
endmodule : lphc_lane_gate

// *** rtl/lphc_regs.sv ***
// apb register bank: lane patterns, hpf config, 16-input pair select
// assumes apb master on pclk; answers with zero wait states
`timescale 1ns/1ps
module lphc_regs
	import lphc_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output lphc_lane_cfg_t lane_cfg, // effective lane patterns
	output lphc_hpf_cfg_t hpf_cfg, // effective filter config
	output logic [3:0] pair_sel // converter 4..1 pair select
);
	logic [15:0] ctrl_r;
	logic [15:0] insel_r;
	logic [15:0] mode_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [15:0] ctrl_nxt;
	logic [15:0] insel_nxt;
	logic [15:0] mode_nxt;

	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic hit_ctrl = paddr[9:0] == LPHC_ADDR_CTRL && paddr[31:10] == 22'h0;
	wire logic hit_insel = paddr[9:0] == LPHC_ADDR_INSEL && paddr[31:10] == 22'h0;
	wire logic hit_mode = paddr[9:0] == LPHC_ADDR_MODE && paddr[31:10] == 22'h0;
	wire logic hit_any = hit_ctrl || hit_insel || hit_mode;
	wire logic wr = access && pwrite && hit_any;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [15:0] mask);
		merge = (old & ~mask) | (d[15:0] & mask);
	endfunction : merge

	// unused bits of the input register are not stored, so they read zero
	assign ctrl_nxt = (wr && hit_ctrl) ? merge(ctrl_r, pwdata, LPHC_CTRL_MASK) : ctrl_r;
	assign insel_nxt = (wr && hit_insel) ? merge(insel_r, pwdata, LPHC_INSEL_MASK) : insel_r;
	assign mode_nxt = (wr && hit_mode) ? merge(mode_r, pwdata, LPHC_MODE_MASK) : mode_r;

	wire logic [31:0] rd_val = hit_ctrl ? {16'h0000, ctrl_r}
		: hit_insel ? {16'h0000, insel_r}
		: hit_mode ? {16'h0000, mode_r}
		: 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= LPHC_RST_VAL;
			insel_r <= LPHC_RST_VAL;
			mode_r <= LPHC_RST_VAL;
		end else begin
			ctrl_r <= ctrl_nxt;
			insel_r <= insel_nxt;
			mode_r <= mode_nxt;
		end
	end

	// read data and error prepared in setup, presented during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr_r <= !hit_any;
		end
	end

	assign pready = 1'b1;
	assign prdata = access ? prdata_r : 32'h0000_0000;
	assign pslverr = access ? pslverr_r : 1'b0;

	wire logic [3:0] prbs_raw = {ctrl_r[LPHC_PRBS_LSB], ctrl_r[LPHC_PRBS_LSB+1],
		ctrl_r[LPHC_PRBS_LSB+2], ctrl_r[LPHC_PRBS_LSB+3]};
	wire logic [2:0] code1 = ctrl_r[LPHC_PAT1_LSB +: 3];
	wire logic [2:0] code2 = ctrl_r[LPHC_PAT2_LSB +: 3];
	wire logic [2:0] code3 = insel_r[LPHC_PAT3_LSB +: 3];
	wire logic [2:0] code4 = insel_r[LPHC_PAT4_LSB +: 3];

	lphc_lane_gate u_gate (
		.ind_sel(mode_r[LPHC_INDSEL_BIT]),
		.prbs_in(prbs_raw),
		.code_in({code4, code3, code2, code1}),
		.lane_out(lane_cfg)
	);

	wire logic [3:0] k_raw = ctrl_r[LPHC_K_LSB +: 4];
	assign hpf_cfg.enable = ctrl_r[LPHC_HPF_EN_BIT];
	assign hpf_cfg.round = ctrl_r[LPHC_ROUND_BIT];
	// k forced to zero while bypassed so downstream never sees a stale corner
	assign hpf_cfg.k = hpf_cfg.enable ? k_raw : 4'h0;
	assign hpf_cfg.k_valid = hpf_cfg.enable && k_raw >= LPHC_K_MIN && k_raw <= LPHC_K_MAX;
	// bit 11 is converter 1, bit 8 converter 4; pair_sel[0] is converter 1
	assign pair_sel = {insel_r[LPHC_INSEL_LSB], insel_r[LPHC_INSEL_LSB+1],
		insel_r[LPHC_INSEL_LSB+2], insel_r[LPHC_INSEL_LSB+3]};

	// lane gating by the individual select bit
	a_gate_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		!mode_r[LPHC_INDSEL_BIT]
		|-> lane_cfg == '0)
		else $error("lane fields active without individual select");

	a_gate_keeps: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_mode
		|=> $stable(ctrl_r) && $stable(insel_r))
		else $error("lane fields lost when select changed");

	a_mode_store: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_mode
		|=> mode_r[LPHC_INDSEL_BIT] == $past(pwdata[0]))
		else $error("individual select not stored");

	a_mode_unused: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> mode_r[15:1] == 15'h0000)
		else $error("unused select bits stored");

	// per-lane prbs enables
	a_prbs_lane1: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl && mode_r[0] && pwdata[15]
		|=> lane_cfg.prbs_en[0])
		else $error("lane 1 prbs not taken from bit 15");

	a_prbs_lane2: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_r[0]
		|-> lane_cfg.prbs_en[1] == ctrl_r[14])
		else $error("lane 2 prbs not bit 14");

	a_prbs_lane3: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_r[0]
		|-> lane_cfg.prbs_en[2] == ctrl_r[13])
		else $error("lane 3 prbs not bit 13");

	a_prbs_lane4: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_r[0]
		|-> lane_cfg.prbs_en[3] == ctrl_r[12])
		else $error("lane 4 prbs not bit 12");

	// per-lane pattern codes
	a_code_lane1: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl && mode_r[0]
		|=> lane_cfg.code[0] == $past(pwdata[11:9]))
		else $error("lane 1 code wrong");

	a_code_lane2: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl && mode_r[0]
		|=> lane_cfg.code[1] == $past(pwdata[8:6]))
		else $error("lane 2 code wrong");

	a_code_lane3: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel && mode_r[0]
		|=> lane_cfg.code[2] == $past(pwdata[7:5]))
		else $error("lane 3 code wrong");

	a_code_lane4: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel && mode_r[0]
		|=> lane_cfg.code[3] == $past(pwdata[4:2]))
		else $error("lane 4 code wrong");

	a_code_state1: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_r[0]
		|-> lane_cfg.code[0] == ctrl_r[11:9] && lane_cfg.code[1] == ctrl_r[8:6])
		else $error("lane 1 or 2 code not from first register");

	a_code_state3: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_r[0]
		|-> lane_cfg.code[2] == insel_r[7:5] && lane_cfg.code[3] == insel_r[4:2])
		else $error("lane 3 or 4 code not from second register");

	// filter configuration
	a_round_bit: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl
		|=> hpf_cfg.round == $past(pwdata[5]))
		else $error("rounding bit not stored");

	a_round_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && hit_ctrl)
		|=> $stable(hpf_cfg.round))
		else $error("rounding bit changed without write");

	a_k_valid: assert property (
		@(posedge pclk) disable iff (!presetn)
		hpf_cfg.k_valid
		|-> hpf_cfg.k inside {[4'h2:4'ha]})
		else $error("k valid outside 2..10");

	a_k_invalid: assert property (
		@(posedge pclk) disable iff (!presetn)
		hpf_cfg.enable && (hpf_cfg.k < 4'h2 || hpf_cfg.k > 4'ha)
		|-> !hpf_cfg.k_valid)
		else $error("k outside 2..10 flagged valid");

	a_k_stored: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl && pwdata[0]
		|=> hpf_cfg.k == $past(pwdata[4:1]))
		else $error("corner k not taken from bits 4-1");

	a_k_bypass: assert property (
		@(posedge pclk) disable iff (!presetn)
		!hpf_cfg.enable
		|-> hpf_cfg.k == 4'h0 && !hpf_cfg.k_valid)
		else $error("corner applied while bypassed");

	a_k_enabled: assert property (
		@(posedge pclk) disable iff (!presetn)
		hpf_cfg.enable
		|-> hpf_cfg.k == ctrl_r[4:1])
		else $error("corner not applied while enabled");

	a_hpf_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ctrl
		|=> hpf_cfg.enable == $past(pwdata[0]))
		else $error("filter enable not bit 0");

	a_hpf_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && hit_ctrl)
		|=> $stable(hpf_cfg.enable))
		else $error("filter enable changed without write");

	// converter input pair selection
	a_pair_conv1: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel
		|=> pair_sel[0] == $past(pwdata[11]))
		else $error("converter 1 pair select wrong");

	a_pair_conv2: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel
		|=> pair_sel[1] == $past(pwdata[10]))
		else $error("converter 2 pair select wrong");

	a_pair_conv3: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel
		|=> pair_sel[2] == $past(pwdata[9]))
		else $error("converter 3 pair select wrong");

	a_pair_conv4: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_insel
		|=> pair_sel[3] == $past(pwdata[8]))
		else $error("converter 4 pair select wrong");

	a_unused_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> insel_r[15:12] == 4'h0 && insel_r[1:0] == 2'b00)
		else $error("unused bits stored");

	// bus behaviour: zero wait states, error only on unmapped words
	a_ready_high: assert property (
		@(posedge pclk) disable iff (!presetn)
		access
		|-> pready)
		else $error("access phase not ready");

	a_rdata_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!access
		|-> prdata == 32'h0000_0000 && !pslverr)
		else $error("read data or error outside access");

	a_rdata_upper: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");

	a_err_unmapped: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !hit_any
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	a_err_mapped: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && hit_any
		|-> !pslverr)
		else $error("mapped access flagged as error");

	a_rd_ctrl: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_ctrl
		|-> prdata == {16'h0000, ctrl_r})
		else $error("first register read back wrong");

	a_rd_insel: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_insel
		|-> prdata == {16'h0000, insel_r})
		else $error("second register read back wrong");

	a_unmapped_nowr: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && !hit_any
		|=> $stable(ctrl_r) && $stable(insel_r) && $stable(mode_r))
		else $error("unmapped write changed a register");
endmodule : lphc_regs

// *** verif/lane_pattern_hpf_input_config_tb.sv ***
// self-checking bench for the lane pattern, filter and input select registers
// assumes lphc_regs on pclk with apb slave ports and zero or more wait states
`timescale 1ns/1ps
module lane_pattern_hpf_input_config_tb;
	import lphc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, m;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pair_sel;
	logic [15:0] c, s;
	lphc_lane_cfg_t lane_cfg;
	lphc_hpf_cfg_t hpf_cfg;
	int num_errors, checked;
	lphc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lane_cfg(lane_cfg), .hpf_cfg(hpf_cfg), .pair_sel(pair_sel));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic eerr,
		input logic [31:0] erd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// request held until the rising edge at which pready is seen high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(32'(n < 50), 32'h1);
		chk(32'(pslverr), 32'(eerr));
		if (!wr) chk(prdata, erd);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task look();
		lphc_lane_cfg_t el;
		lphc_hpf_cfg_t eh;
		el = '0;
		if (m) el = {c[12], c[13], c[14], c[15], s[4:2], s[7:5], c[8:6], c[11:9]};
		eh = {c[0], c[5], c[0] ? c[4:1] : 4'h0, c[0] && c[4:1] >= 4'h2 && c[4:1] <= 4'ha};
		@(negedge pclk);
		chk(32'(lane_cfg), 32'(el));
		chk(32'(hpf_cfg), 32'(eh));
		chk(32'(pair_sel), {28'h0, s[8], s[9], s[10], s[11]});
		apb(1'b0, 32'(LPHC_ADDR_CTRL), 32'h0, 1'b0, {16'h0, c});
		apb(1'b0, 32'(LPHC_ADDR_INSEL), 32'h0, 1'b0, {16'h0, s & 16'h0ffc});
		apb(1'b0, 32'(LPHC_ADDR_MODE), 32'h0, 1'b0, {31'h0, m});
	endtask : look
	task put();
		apb(1'b1, 32'(LPHC_ADDR_CTRL), {16'h0, c}, 1'b0, 32'h0);
		apb(1'b1, 32'(LPHC_ADDR_INSEL), {16'h0, s}, 1'b0, 32'h0);
		apb(1'b1, 32'(LPHC_ADDR_MODE), {31'h0, m}, 1'b0, 32'h0);
		look();
	endtask : put
	task t_reset();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		{c, s, m} = '0;
		look();
		$display("test reset done");
	endtask : t_reset
	task t_lanes();
		c = 16'ha2c0;
		s = 16'h0a74;
		for (int i = 0; i < 3; i++) begin
			// select cleared again last: fields must be hidden yet kept
			m = (i == 1);
			put();
		end
		c = 16'h5d00;
		s = 16'h0588;
		m = 1'b1;
		put();
		$display("test lanes done");
	endtask : t_lanes
	task t_filter();
		logic [3:0] ks[6] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'hb, 4'hf};
		foreach (ks[i]) begin
			for (int e = 0; e < 2; e++) begin
				c = {10'h2a7, ks[i][0], ks[i], e[0]};
				put();
			end
		end
		$display("test filter done");
	endtask : t_filter
	task t_insel();
		for (int i = 0; i < 4; i++) begin
			s = 16'h0100 << i;
			put();
		end
		s = 16'hffff;
		put();
		apb(1'b1, 32'h58, 32'hffff, 1'b1, 32'h0);
		apb(1'b0, 32'h58, 32'h0, 1'b1, 32'h0);
		look();
		$display("test select and unmapped done");
	endtask : t_insel
	task final_report();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		t_reset();
		t_lanes();
		t_filter();
		t_insel();
		t_reset();
		final_report();
	end
	initial begin
		// tests take well under 20 us at 100 MHz
		#200us;
		num_errors++;
		final_report();
	end
endmodule : lane_pattern_hpf_input_config_tb
